// ---- pts_client.sv ----
// The APB register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
module pts_client (
    input wire logic pclk,
    input wire logic presetn,
    pts_if.cli link,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq
);
    logic [pts_pkg::CTRL_W-1:0] ctrl_reg;
    logic [pts_pkg::IRQ_W-1:0] stat_reg, stat_next, mask_reg;
    logic [pts_pkg::TIME_W-1:0] time_reg, time_next, cap_reg, txs_reg;
    logic [pts_pkg::LANE_W-1:0] cap_lane_reg, fill_sel_reg;
    logic [31:0] ofs_reg, rd_mux;
    logic [1:0] fault_d_reg;
    logic pready_reg, pslverr_reg, irq_reg;
    logic [31:0] prdata_reg;
    logic [1:0] op_sel;
    logic [pts_pkg::OFS_W:0] ck_limit;
    logic [pts_pkg::FILL_W-1:0] fill_rd;
    logic [32:0] ns_sum;
    logic [pts_pkg::TC_NS_W-1:0] tc_ns;
    logic setup, wr_fire, hit;
    logic [pts_pkg::IRQ_W-1:0] ev_set, w1c;

    // zero-wait slave: answer is prepared during the setup cycle
    assign setup = psel & ~penable;
    assign wr_fire = psel & penable & pready_reg & pwrite;

    // reserved code never reaches the device
    assign op_sel = (ctrl_reg[pts_pkg::CTRL_OP_LSB +: 2] ==
                     pts_pkg::OP_RESERVED) ? pts_pkg::OP_NONE
                    : ctrl_reg[pts_pkg::CTRL_OP_LSB +: 2];

    assign ck_limit = {1'b0, ofs_reg[31:16]} + pts_pkg::TC_CK_MARGIN;
    assign link.tx_tstamp_ofs = (ctrl_reg[pts_pkg::CTRL_TC] &&
        ctrl_reg[pts_pkg::CTRL_UPD] && op_sel == pts_pkg::OP_ONE_STEP &&
        {1'b0, ofs_reg[15:0]} > ck_limit) ? ck_limit[15:0] : ofs_reg[15:0];

    // control wires toward the device, all from registers
    assign link.time_ref = time_reg;
    assign link.tc_mode = ctrl_reg[pts_pkg::CTRL_TC];
    assign link.tx_timing_operation_select = op_sel;
    assign link.tx_adjust_mode = ctrl_reg[pts_pkg::CTRL_ADJ];
    assign link.tx_path_reset = ctrl_reg[pts_pkg::CTRL_TXRST];
    assign link.tx_chksum_ofs = ofs_reg[31:16];
    assign link.tx_upd_chksum = ctrl_reg[pts_pkg::CTRL_UPD];

    // time counter on the receive clock
    assign ns_sum = {1'b0, time_reg[31:0]} + 33'(pts_pkg::CLK_PERIOD_NS);
    assign tc_ns = time_reg[pts_pkg::TC_NS_MSB:pts_pkg::TC_NS_LSB] +
                   pts_pkg::TC_NS_W'(pts_pkg::CLK_PERIOD_NS);
    assign time_next = ctrl_reg[pts_pkg::CTRL_TC]
        ? {time_reg[79:63], tc_ns, time_reg[15:0]}
        : (ns_sum >= pts_pkg::NS_PER_SEC)
        ? {time_reg[79:32] + 48'h1, 32'(ns_sum - pts_pkg::NS_PER_SEC)}
        : {time_reg[79:32], ns_sum[31:0]};

    // events; a set in the clearing cycle wins
    assign ev_set = {link.tx_rd_fault & ~fault_d_reg[1],
                     link.tx_wr_fault & ~fault_d_reg[0],
                     link.tx_stamp_valid, link.rx_sop};
    assign w1c = (wr_fire && paddr == pts_pkg::REG_IRQ_STAT)
                 ? pwdata[pts_pkg::IRQ_W-1:0] : pts_pkg::IRQ_RST;
    assign stat_next = (stat_reg & ~w1c) | ev_set;

    // read decode
    assign fill_rd = link.rx_lane_fill[fill_sel_reg * pts_pkg::FILL_W +:
                                       pts_pkg::FILL_W];
    assign hit = paddr inside {pts_pkg::REG_CTRL, pts_pkg::REG_STATUS,
        pts_pkg::REG_IRQ_STAT, pts_pkg::REG_IRQ_MASK, pts_pkg::REG_TIME0,
        pts_pkg::REG_TIME1, pts_pkg::REG_TIME2, pts_pkg::REG_CAP0,
        pts_pkg::REG_CAP1, pts_pkg::REG_CAP2, pts_pkg::REG_FILL,
        pts_pkg::REG_TX_OFS, pts_pkg::REG_TXS0, pts_pkg::REG_TXS1,
        pts_pkg::REG_TXS2};
    always_comb begin
        rd_mux = 32'h0;
        unique case (paddr)
            pts_pkg::REG_CTRL: rd_mux = 32'(ctrl_reg);
            pts_pkg::REG_STATUS:
                rd_mux = {30'h0, link.tx_rd_fault, link.tx_wr_fault};
            pts_pkg::REG_IRQ_STAT: rd_mux = 32'(stat_reg);
            pts_pkg::REG_IRQ_MASK: rd_mux = 32'(mask_reg);
            pts_pkg::REG_TIME0: rd_mux = time_reg[31:0];
            pts_pkg::REG_TIME1: rd_mux = time_reg[63:32];
            pts_pkg::REG_TIME2: rd_mux = {16'h0, time_reg[79:64]};
            pts_pkg::REG_CAP0: rd_mux = cap_reg[31:0];
            pts_pkg::REG_CAP1: rd_mux = cap_reg[63:32];
            pts_pkg::REG_CAP2:
                rd_mux = {11'h0, cap_lane_reg, cap_reg[79:64]};
            pts_pkg::REG_FILL: rd_mux = {17'h0, fill_rd,
                                         3'h0, fill_sel_reg};
            pts_pkg::REG_TX_OFS: rd_mux = ofs_reg;
            pts_pkg::REG_TXS0: rd_mux = txs_reg[31:0];
            pts_pkg::REG_TXS1: rd_mux = txs_reg[63:32];
            pts_pkg::REG_TXS2: rd_mux = {16'h0, txs_reg[79:64]};
            default: rd_mux = 32'h0;
        endcase
    end

    // bus answer flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0;
        end else begin
            pready_reg <= setup;
            pslverr_reg <= setup & ~hit;
            prdata_reg <= (setup && !pwrite) ? rd_mux : 32'h0;
        end
    end

    // software registers; a write to time overrides the advance
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= pts_pkg::CTRL_RST;
            mask_reg <= pts_pkg::IRQ_RST;
            ofs_reg <= 32'h0;
            fill_sel_reg <= '0;
            time_reg <= '0;
        end else begin
            time_reg <= time_next;
            if (wr_fire) begin
                unique case (paddr)
                    pts_pkg::REG_CTRL: ctrl_reg <= pwdata[5:0];
                    pts_pkg::REG_IRQ_MASK: mask_reg <= pwdata[3:0];
                    pts_pkg::REG_TX_OFS: ofs_reg <= pwdata;
                    pts_pkg::REG_FILL: fill_sel_reg <= (pwdata[4:0] <
                        5'(pts_pkg::LANES)) ? pwdata[4:0] : fill_sel_reg;
                    pts_pkg::REG_TIME0: time_reg[31:0] <= pwdata;
                    pts_pkg::REG_TIME1: time_reg[63:32] <= pwdata;
                    pts_pkg::REG_TIME2: time_reg[79:64] <= pwdata[15:0];
                    default: ;
                endcase
            end
        end
    end

    // captures from the device and interrupt state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_reg <= '0;
            cap_lane_reg <= '0;
            txs_reg <= '0;
            stat_reg <= pts_pkg::IRQ_RST;
            fault_d_reg <= 2'h0;
            irq_reg <= 1'b0;
        end else begin
            if (link.rx_sop) begin
                cap_reg <= link.rx_cap_time;
                cap_lane_reg <= link.rx_sop_lane;
            end
            if (link.tx_stamp_valid) txs_reg <= link.tx_stamp;
            stat_reg <= stat_next;
            fault_d_reg <= {link.tx_rd_fault, link.tx_wr_fault};
            irq_reg <= |(stat_next & mask_reg);
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign irq = irq_reg;
endmodule : pts_client

// ---- pts_pkg.sv ----
package pts_pkg;
    // time reference layout, shared by both ends
    localparam int TIME_W = 80;
    localparam int NS_W = 32;
    localparam int SEC_W = 48;
    localparam int TC_SIGN_BIT = 63;
    localparam int TC_NS_MSB = 62;
    localparam int TC_NS_LSB = 16;
    localparam int TC_NS_W = TC_NS_MSB - TC_NS_LSB + 1;
    localparam logic [32:0] NS_PER_SEC = 33'h03B9ACA00;
    // lane and fill geometry
    localparam int LANES = 20;
    localparam int LANE_W = 5;
    localparam int FILL_W = 7;
    localparam int OFS_W = 16;
    localparam int ADJ_W = 16;
    localparam logic [OFS_W:0] TC_CK_MARGIN = 17'h00022;
    // transmit timing operation codes
    localparam logic [1:0] OP_NONE = 2'h0;
    localparam logic [1:0] OP_ONE_STEP = 2'h1;
    localparam logic [1:0] OP_TWO_STEP = 2'h2;
    localparam logic [1:0] OP_RESERVED = 2'h3;
    // clock and default skew step per lane
    localparam int CLK_PERIOD_NS = 10;
    localparam logic [ADJ_W-1:0] LANE_SKEW_NS = 16'h0008;
    // client register offsets
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam logic [11:0] REG_IRQ_STAT = 12'h008;
    localparam logic [11:0] REG_IRQ_MASK = 12'h00C;
    localparam logic [11:0] REG_TIME0 = 12'h010;
    localparam logic [11:0] REG_TIME1 = 12'h014;
    localparam logic [11:0] REG_TIME2 = 12'h018;
    localparam logic [11:0] REG_CAP0 = 12'h01C;
    localparam logic [11:0] REG_CAP1 = 12'h020;
    localparam logic [11:0] REG_CAP2 = 12'h024;
    localparam logic [11:0] REG_FILL = 12'h028;
    localparam logic [11:0] REG_TX_OFS = 12'h02C;
    localparam logic [11:0] REG_TXS0 = 12'h030;
    localparam logic [11:0] REG_TXS1 = 12'h034;
    localparam logic [11:0] REG_TXS2 = 12'h038;
    // control fields
    localparam int CTRL_ADJ = 0;
    localparam int CTRL_TC = 1;
    localparam int CTRL_TXRST = 2;
    localparam int CTRL_UPD = 3;
    localparam int CTRL_OP_LSB = 4;
    localparam int CTRL_W = 6;
    localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
    // interrupt fields
    localparam int IRQ_RXSOP = 0;
    localparam int IRQ_TXSTAMP = 1;
    localparam int IRQ_WRF = 2;
    localparam int IRQ_RDF = 3;
    localparam int IRQ_W = 4;
    localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0;
    localparam int FILL_RD_LSB = 8;
endpackage : pts_pkg

// ---- pts_if.sv ----
`timescale 1ns/1ns
interface pts_if;
    // client to device
    logic [pts_pkg::TIME_W-1:0] time_ref;
    logic tc_mode;
    logic [1:0] tx_timing_operation_select;
    logic tx_adjust_mode;
    logic tx_path_reset;
    logic [pts_pkg::OFS_W-1:0] tx_tstamp_ofs;
    logic [pts_pkg::OFS_W-1:0] tx_chksum_ofs;
    logic tx_upd_chksum;
    // device to client
    logic rx_sop;
    logic [pts_pkg::TIME_W-1:0] rx_cap_time;
    logic [pts_pkg::LANE_W-1:0] rx_sop_lane;
    logic [pts_pkg::LANES*pts_pkg::FILL_W-1:0] rx_lane_fill;
    logic tx_stamp_valid;
    logic [pts_pkg::TIME_W-1:0] tx_stamp;
    logic tx_wr_fault;
    logic tx_rd_fault;

    modport dev (
        input time_ref, tc_mode, tx_timing_operation_select,
        input tx_adjust_mode, tx_path_reset, tx_tstamp_ofs,
        input tx_chksum_ofs, tx_upd_chksum,
        output rx_sop, rx_cap_time, rx_sop_lane, rx_lane_fill,
        output tx_stamp_valid, tx_stamp, tx_wr_fault, tx_rd_fault
    );
    modport cli (
        output time_ref, tc_mode, tx_timing_operation_select,
        output tx_adjust_mode, tx_path_reset, tx_tstamp_ofs,
        output tx_chksum_ofs, tx_upd_chksum,
        input rx_sop, rx_cap_time, rx_sop_lane, rx_lane_fill,
        input tx_stamp_valid, tx_stamp, tx_wr_fault, tx_rd_fault
    );
endinterface : pts_if

// ---- pts_device.sv ----
`timescale 1ns/1ns
//
// Function
// - client keeps insert offset within checksum plus 34 in transparent mode, 1-step, checksum update on
// - lane skew adjust corrects transmit stamps by lane
// - adjustment applies to 1-step frames only
// - write fault sticky until transmit path reset
// - read fault sticky until transmit path reset
// - normal mode: 48 seconds then 32 nanoseconds
// - transparent mode: sign, nanoseconds, fractional nanoseconds
// - client drives time reference on lane 0 clock
// - capture time valid with start of packet
// - 5-bit lane index valid with start of packet
// - per-lane 7-bit deskew fill level exported
// - client selects 2-bit transmit timing operation
module pts_device #(
    parameter logic [pts_pkg::ADJ_W-1:0] LANE_SKEW = pts_pkg::LANE_SKEW_NS
) (
    input wire logic pclk,
    input wire logic presetn,
    pts_if.dev link,
    input wire logic sop_in,
    input wire logic [pts_pkg::LANE_W-1:0] sop_lane_in,
    input wire logic [pts_pkg::LANES*pts_pkg::FILL_W-1:0] lane_fill_in,
    input wire logic tx_sop_in,
    input wire logic [pts_pkg::LANE_W-1:0] tx_sop_lane_in,
    input wire logic tag_wr_err_in,
    input wire logic tag_rd_err_in,
    output logic tx_ins_valid,
    output logic [pts_pkg::OFS_W-1:0] tx_ins_ofs,
    output logic [pts_pkg::OFS_W-1:0] tx_ck_ofs,
    output logic tx_ck_upd
);
    localparam int FW = pts_pkg::FILL_W;
    localparam int TW = pts_pkg::TIME_W;

    logic rx_sop_reg;
    logic [TW-1:0] rx_cap_reg;
    logic [pts_pkg::LANE_W-1:0] rx_lane_reg;
    logic [FW-1:0] fill_reg [pts_pkg::LANES];
    logic tx_valid_reg, tx_valid_next;
    logic [TW-1:0] tx_stamp_reg, tx_stamp_next;
    logic wr_fault_reg, wr_fault_next;
    logic rd_fault_reg, rd_fault_next;
    logic ins_valid_reg;
    logic [pts_pkg::OFS_W-1:0] ins_ofs_reg, ck_ofs_reg;
    logic ck_upd_reg;
    logic [1:0] op;
    logic stamp_req, one_step, do_adjust;
    logic [pts_pkg::ADJ_W-1:0] lane_adj;
    logic [TW-1:0] adjusted;

    // time plus a nanosecond offset, in the format that mode selects
    function automatic logic [TW-1:0] pts_add_ns(
        input logic [TW-1:0] t,
        input logic [pts_pkg::ADJ_W-1:0] adj,
        input logic tc
    );
        logic [32:0] ns;
        logic [pts_pkg::TC_NS_W-1:0] tcn;
        logic [TW-1:0] r;
        ns = {1'b0, t[pts_pkg::NS_W-1:0]} + 33'(adj);
        tcn = t[pts_pkg::TC_NS_MSB:pts_pkg::TC_NS_LSB] +
              pts_pkg::TC_NS_W'(adj);
        if (tc) begin
            // sign and fraction stay; magnitude only grows
            r = {t[TW-1:pts_pkg::TC_SIGN_BIT], tcn,
                 t[pts_pkg::TC_NS_LSB-1:0]};
        end else if (ns >= pts_pkg::NS_PER_SEC) begin
            // nanosecond field wraps into the seconds field
            r = {t[TW-1:pts_pkg::NS_W] + 48'h1,
                 32'(ns - pts_pkg::NS_PER_SEC)};
        end else begin
            r = {t[TW-1:pts_pkg::NS_W], ns[pts_pkg::NS_W-1:0]};
        end
        return r;
    endfunction : pts_add_ns

    // transmit request decode
    assign op = link.tx_timing_operation_select;
    assign one_step = (op == pts_pkg::OP_ONE_STEP);
    assign stamp_req = tx_sop_in & ~link.tx_path_reset &
                       (one_step | (op == pts_pkg::OP_TWO_STEP));

    assign lane_adj = pts_pkg::ADJ_W'(tx_sop_lane_in * LANE_SKEW);
    assign do_adjust = link.tx_adjust_mode & one_step;
    assign adjusted = pts_add_ns(link.time_ref, lane_adj, link.tc_mode);

    // stamp is the reference as seen at the capture plane
    assign tx_valid_next = stamp_req;
    assign tx_stamp_next = !stamp_req ? tx_stamp_reg
                           : do_adjust ? adjusted : link.time_ref;

    assign wr_fault_next = link.tx_path_reset ? 1'b0
                           : (wr_fault_reg | tag_wr_err_in);
    assign rd_fault_next = link.tx_path_reset ? 1'b0
                           : (rd_fault_reg | tag_rd_err_in);

    // capture time and lane with the start of packet
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_sop_reg <= 1'b0;
            rx_cap_reg <= '0;
            rx_lane_reg <= '0;
        end else begin
            rx_sop_reg <= sop_in;
            if (sop_in) begin
                // time reference is already on this clock, no crossing
                rx_cap_reg <= link.time_ref;
                rx_lane_reg <= sop_lane_in;
            end
        end
    end

    for (genvar i = 0; i < pts_pkg::LANES; i++) begin : g_fill
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                fill_reg[i] <= '0;
            end else begin
                fill_reg[i] <= lane_fill_in[i*FW +: FW];
            end
        end
        assign link.rx_lane_fill[i*FW +: FW] = fill_reg[i];
    end

    // flags cleared by power-on and transmit path reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_fault_reg <= 1'b0;
            rd_fault_reg <= 1'b0;
        end else begin
            wr_fault_reg <= wr_fault_next;
            rd_fault_reg <= rd_fault_next;
        end
    end

    // transmit stamp and insert offsets for the datapath
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_valid_reg <= 1'b0;
            tx_stamp_reg <= '0;
            ins_valid_reg <= 1'b0;
            ins_ofs_reg <= '0;
            ck_ofs_reg <= '0;
            ck_upd_reg <= 1'b0;
        end else begin
            tx_valid_reg <= tx_valid_next;
            tx_stamp_reg <= tx_stamp_next;
            ins_valid_reg <= stamp_req & one_step;
            if (stamp_req & one_step) begin
                // offsets trusted as the client bounded them
                ins_ofs_reg <= link.tx_tstamp_ofs;
                ck_ofs_reg <= link.tx_chksum_ofs;
                ck_upd_reg <= link.tx_upd_chksum;
            end
        end
    end

    // outputs straight from flops
    assign link.rx_sop = rx_sop_reg;
    assign link.rx_cap_time = rx_cap_reg;
    assign link.rx_sop_lane = rx_lane_reg;
    assign link.tx_stamp_valid = tx_valid_reg;
    assign link.tx_stamp = tx_stamp_reg;
    assign link.tx_wr_fault = wr_fault_reg;
    assign link.tx_rd_fault = rd_fault_reg;
    assign tx_ins_valid = ins_valid_reg;
    assign tx_ins_ofs = ins_ofs_reg;
    assign tx_ck_ofs = ck_ofs_reg;
    assign tx_ck_upd = ck_upd_reg;
endmodule : pts_device

// ---- pts_assertions.sv ----
`timescale 1ns/1ns
module pts_assertions (
    input logic pclk,
    input logic presetn,
    input logic tc_mode,
    input logic [1:0] tx_timing_operation_select,
    input logic tx_path_reset,
    input logic [pts_pkg::OFS_W-1:0] tx_tstamp_ofs,
    input logic [pts_pkg::OFS_W-1:0] tx_chksum_ofs,
    input logic tx_upd_chksum,
    input logic rx_sop,
    input logic [pts_pkg::TIME_W-1:0] rx_cap_time,
    input logic [pts_pkg::LANE_W-1:0] rx_sop_lane,
    input logic tx_stamp_valid,
    input logic [pts_pkg::TIME_W-1:0] tx_stamp,
    input logic tx_wr_fault,
    input logic tx_rd_fault
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // faults hold until a path reset, which clears both one edge later
    a_wr_fault_sticky: assert property (
        tx_wr_fault && !tx_path_reset |=> tx_wr_fault)
        else $error("write fault dropped without path reset");
    a_rd_fault_sticky: assert property (
        tx_rd_fault && !tx_path_reset |=> tx_rd_fault)
        else $error("read fault dropped without path reset");
    a_fault_clear: assert property (
        tx_path_reset |=> !tx_wr_fault && !tx_rd_fault)
        else $error("fault flag survived path reset");
    // capture time and lane only move with a start of packet
    a_cap_hold: assert property (!rx_sop |-> $stable(rx_cap_time))
        else $error("capture time changed without start of packet");
    a_lane_hold: assert property (!rx_sop |-> $stable(rx_sop_lane))
        else $error("lane index changed without start of packet");
    a_lane_range: assert property (rx_sop |-> rx_sop_lane < 5'h14)
        else $error("lane index beyond last lane");
    a_stamp_blocked: assert property (
        tx_path_reset |=> !tx_stamp_valid)
        else $error("stamp issued while path in reset");
    // the clamp keeps the insert offset inside the checksum window
    a_offset_clamp: assert property (tc_mode && tx_upd_chksum
        && tx_timing_operation_select == pts_pkg::OP_ONE_STEP
        |-> {1'h0, tx_tstamp_ofs} <=
            {1'h0, tx_chksum_ofs} + pts_pkg::TC_CK_MARGIN)
        else $error("insert offset beyond checksum window");
    a_op_legal: assert property (
        tx_timing_operation_select != pts_pkg::OP_RESERVED)
        else $error("reserved timing operation sent");

    c_rx_sop: cover property (rx_sop ##1 rx_sop);
    c_tx_stamp: cover property (tx_stamp_valid);
    c_fault: cover property (tx_wr_fault && tx_rd_fault);
    c_reset: cover property (tx_wr_fault ##1 tx_path_reset);
endmodule : pts_assertions

// ---- tb.sv ----
`timescale 1ns/1ns
module tb;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, irq;
    logic sop_in = 1'h0;
    logic tx_sop_in = 1'h0;
    logic wr_err = 1'h0;
    logic rd_err = 1'h0;
    logic [4:0] sop_lane = 5'h00;
    logic [4:0] tx_lane = 5'h00;
    logic [139:0] fill = 140'h0;
    logic [1:0] op = 2'h0;
    logic adj = 1'h0;
    logic tc = 1'h0;
    logic ins_v, ck_upd;
    logic [15:0] ins_ofs, ck_ofs;
    int n_mismatch = 0;
    int n_checks = 0;
    integer seed = 32'hA9B17A42;
    logic [84:0] rx_q[$];
    logic [84:0] tx_q[$];
    logic [84:0] rd_q[$];

    pts_if link_if ();
    always #5 pclk = ~pclk;

    pts_client pts_client_inst (.pclk(pclk), .presetn(presetn),
        .link(link_if), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq));
    pts_device pts_device_inst (.pclk(pclk), .presetn(presetn),
        .link(link_if), .sop_in(sop_in), .sop_lane_in(sop_lane),
        .lane_fill_in(fill), .tx_sop_in(tx_sop_in), .tx_sop_lane_in(tx_lane),
        .tag_wr_err_in(wr_err), .tag_rd_err_in(rd_err), .tx_ins_valid(ins_v),
        .tx_ins_ofs(ins_ofs), .tx_ck_ofs(ck_ofs), .tx_ck_upd(ck_upd));
    pts_assertions pts_assertions_inst (.pclk(pclk), .presetn(presetn),
        .tc_mode(link_if.tc_mode),
        .tx_timing_operation_select(link_if.tx_timing_operation_select),
        .tx_path_reset(link_if.tx_path_reset),
        .tx_tstamp_ofs(link_if.tx_tstamp_ofs),
        .tx_chksum_ofs(link_if.tx_chksum_ofs),
        .tx_upd_chksum(link_if.tx_upd_chksum), .rx_sop(link_if.rx_sop),
        .rx_cap_time(link_if.rx_cap_time), .rx_sop_lane(link_if.rx_sop_lane),
        .tx_stamp_valid(link_if.tx_stamp_valid), .tx_stamp(link_if.tx_stamp),
        .tx_wr_fault(link_if.tx_wr_fault), .tx_rd_fault(link_if.tx_rd_fault));

    task automatic compare(input string what, input logic [84:0] exp,
            input logic [84:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : compare

    // an empty queue yields unknown, so a stray result always mismatches
    function automatic logic [84:0] pop(ref logic [84:0] q[$]);
        return (q.size() != 0) ? q.pop_front() : 'x;
    endfunction : pop

    // lane correction only for 1-step with adjust on; ns wraps into seconds
    function automatic logic [79:0] stamp_exp(input logic [79:0] t,
            input logic [4:0] l);
        logic [15:0] a;
        logic [32:0] ns;
        a = (op == pts_pkg::OP_ONE_STEP && adj) ?
            16'(l) * pts_pkg::LANE_SKEW_NS : 16'h0;
        if (tc) begin
            t[62:16] = t[62:16] + 47'(a);
            return t;
        end
        ns = {1'h0, t[31:0]} + 33'(a);
        if (ns >= pts_pkg::NS_PER_SEC) begin
            ns = ns - pts_pkg::NS_PER_SEC;
            t[79:32] = t[79:32] + 48'h1;
        end
        t[31:0] = ns[31:0];
        return t;
    endfunction : stamp_exp

    // results are taken at the edge where they are seen, before updates
    always @(posedge pclk) begin
        if (link_if.rx_sop === 1'h1)
            compare("rx capture", pop(rx_q),
                {link_if.rx_cap_time, link_if.rx_sop_lane});
        if (link_if.tx_stamp_valid === 1'h1)
            compare("tx stamp", pop(tx_q),
                {4'h0, ins_v, link_if.tx_stamp});
        if (psel && penable && pready === 1'h1 && !pwrite)
            compare("apb read", pop(rd_q), {52'h0, pslverr, prdata});
    end

    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] d, input logic [32:0] e);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        if (!w)
            rd_q.push_back({52'h0, e});
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    task automatic set(input logic [1:0] o, input logic a, input logic t,
            input logic u);
        op = o;
        adj = a;
        tc = t;
        apb(1'h1, pts_pkg::REG_CTRL, {26'h0, o, u, 1'h0, t, a}, 33'h0);
    endtask : set

    // n starts of packet on consecutive cycles, random lanes
    task automatic ev(input logic k, input int n);
        logic [4:0] l;
        @(posedge pclk);
        repeat (n) begin
            l = 5'($unsigned($random(seed)) % 20);
            sop_in <= !k;
            tx_sop_in <= k;
            sop_lane <= l;
            tx_lane <= l;
            @(negedge pclk);
            if (!k)
                rx_q.push_back({link_if.time_ref, l});
            else if (op == pts_pkg::OP_ONE_STEP || op == pts_pkg::OP_TWO_STEP)
                // insert strobe rides with the stamp, 1-step frames only
                tx_q.push_back({4'h0, op == pts_pkg::OP_ONE_STEP,
                    stamp_exp(link_if.time_ref, l)});
            @(posedge pclk);
        end
        sop_in <= 1'h0;
        tx_sop_in <= 1'h0;
    endtask : ev

    // error pulse, then time for flag, status and irq to settle
    task automatic pulse(input logic r);
        @(posedge pclk);
        rd_err <= r;
        wr_err <= !r;
        @(posedge pclk);
        rd_err <= 1'h0;
        wr_err <= 1'h0;
        repeat (5) @(posedge pclk);
    endtask : pulse

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : test_done

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'h1;
        apb(1'h0, pts_pkg::REG_STATUS, 32'h0, 33'h0);
        ev(1'h0, 1);
        ev(1'h0, 4);
        fill <= 140'({$random(seed), $random(seed), $random(seed),
            $random(seed), $random(seed)});
        repeat (3) @(posedge pclk);
        compare("lane fill", 85'(fill), 85'(link_if.rx_lane_fill));
        compare("lane fill hi", 85'(fill[139:85]),
            85'(link_if.rx_lane_fill[139:85]));
        apb(1'h1, pts_pkg::REG_FILL, 32'h13, 33'h0);
        apb(1'h1, pts_pkg::REG_FILL, 32'h14, 33'h0);
        apb(1'h0, pts_pkg::REG_FILL, 32'h0,
            {18'h0, fill[139:133], 8'h13});
        apb(1'h0, 12'h0FC, 32'h0, {1'h1, 32'h0});
        for (int i = 0; i < 8; i++) begin
            set(i[1:0], i[2], 1'h0, 1'h0);
            ev(1'h1, 2);
        end
        set(pts_pkg::OP_ONE_STEP, 1'h1, 1'h1, 1'h1);
        ev(1'h1, 3);
        ev(1'h0, 2);
        apb(1'h1, pts_pkg::REG_TX_OFS, 32'h000A0064, 33'h0);
        repeat (3) @(posedge pclk);
        compare("insert offset", 85'h2C, 85'(link_if.tx_tstamp_ofs));
        // one more 1-step frame latches the clamped offsets downstream
        ev(1'h1, 1);
        repeat (2) @(posedge pclk);
        compare("insert offsets", 85'({16'h2C, 16'hA, 1'h1}),
            85'({ins_ofs, ck_ofs, ck_upd}));
        set(pts_pkg::OP_NONE, 1'h0, 1'h0, 1'h0);
        apb(1'h1, pts_pkg::REG_IRQ_STAT, 32'hF, 33'h0);
        apb(1'h1, pts_pkg::REG_IRQ_MASK, 32'h4, 33'h0);
        pulse(1'h0);
        compare("irq", 85'h1, 85'(irq));
        apb(1'h0, pts_pkg::REG_STATUS, 32'h0, 33'h1);
        pulse(1'h1);
        apb(1'h0, pts_pkg::REG_STATUS, 32'h0, 33'h3);
        apb(1'h0, pts_pkg::REG_IRQ_STAT, 32'h0, 33'hC);
        apb(1'h1, pts_pkg::REG_IRQ_MASK, 32'h0, 33'h0);
        repeat (3) @(posedge pclk);
        compare("irq masked", 85'h0, 85'(irq));
        apb(1'h1, pts_pkg::REG_IRQ_STAT, 32'h4, 33'h0);
        apb(1'h1, pts_pkg::REG_IRQ_MASK, 32'h4, 33'h0);
        repeat (3) @(posedge pclk);
        compare("irq cleared", 85'h0, 85'(irq));
        apb(1'h0, pts_pkg::REG_STATUS, 32'h0, 33'h3);
        apb(1'h1, pts_pkg::REG_CTRL, 32'h4, 33'h0);
        apb(1'h1, pts_pkg::REG_CTRL, 32'h0, 33'h0);
        apb(1'h0, pts_pkg::REG_STATUS, 32'h0, 33'h0);
        repeat (3) @(posedge pclk);
        compare("leftover", 85'h0,
            85'(rx_q.size() + tx_q.size() + rd_q.size()));
        test_done();
    end

    // the sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge pclk);
        n_mismatch++;
        test_done();
    end
endmodule : tb
